// ==== bench/cpu_bus_model.sv ====
/*
  Processor bus master model: I/O writes and reads, memory and fetch
  cycles, and the mode set that start-up software performs.
  Assumes ce is high, so every clk edge is one processor clock.
*/
`default_nettype none

module cpu_bus_model (
  input wire logic clk,
  output glue_pkg::cpu_bus_t bus,
  input wire logic [7:0] data_out,
  input wire logic data_drive_n,
  input wire logic wait_n,
  input wire glue_pkg::mem_sel_t mem_sel
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Idle bus at time zero, every strobe high
  initial begin
    bus = {16'h0000, 8'h00, 5'h1F};
  end

  // Release strobes; data flips so a stale byte never looks valid
  task automatic idle();
    bus.mreq_n <= 1'b1;
    bus.iorq_n <= 1'b1;
    bus.rd_n <= 1'b1;
    bus.wr_n <= 1'b1;
    bus.m1_n <= 1'b1;
    bus.data <= ~bus.data;
  endtask : idle

  task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus.addr <= {8'h00, a};
    bus.data <= d;
    bus.iorq_n <= 1'b0;
    bus.wr_n <= 1'b0;
    @(posedge clk);
    idle();
    @(posedge clk);
  endtask : io_wr

  // Answer is taken one clock after the request is driven
  task automatic io_rd(input logic [7:0] a, output logic [7:0] d,
                       output logic drv_n);
    @(posedge clk);
    bus.addr <= {8'h00, a};
    bus.iorq_n <= 1'b0;
    bus.rd_n <= 1'b0;
    @(posedge clk);
    #1;
    d = data_out;
    drv_n = data_drive_n;
    @(posedge clk);
    idle();
    @(posedge clk);
  endtask : io_rd

  // Fetch is held two clocks so a second wait would show in w2
  task automatic mem(input logic [15:0] a, input logic rd, input logic m1,
                     output glue_pkg::mem_sel_t s,
                     output glue_pkg::mem_sel_t s_after,
                     output logic w1, output logic w2);
    @(posedge clk);
    bus.addr <= a;
    bus.mreq_n <= 1'b0;
    bus.rd_n <= ~rd;
    bus.wr_n <= rd;
    bus.m1_n <= ~m1;
    @(posedge clk);
    #1;
    s = mem_sel;
    w1 = wait_n;
    @(posedge clk);
    idle();
    #1;
    w2 = wait_n;
    @(posedge clk);
    #1;
    s_after = mem_sel;
  endtask : mem

  // Start-up software puts the parallel chip in mode 0
  task automatic set_mode0();
    io_wr(glue_pkg::IO_PIO_CTRL, 8'h80);
  endtask : set_mode0
endmodule : cpu_bus_model

`default_nettype wire

// ==== bench/slot_select_and_system_io_bench.sv ====
/*
  Self-checking bench of the system glue: reset, then slot decode table,
  fetch wait, port bits, sound chip ports and interrupt merge by hand.
  Assumes ce held high except where the bench drops it to check freezing; the bus model stands in for the processor.
*/
`default_nettype none

module slot_select_and_system_io_bench;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [7:0] sel;
    logic [15:0] addr;
    logic rd;
    logic [5:0] exp;
  } row_t;

  // ----------------------------------------------------------------
  // Signals and design
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [2:0] slot_int_n = 3'h7;
  logic [7:0] key_sense_inputs = 8'h00;
  logic [5:0] first_stick_lines = 6'h15;
  logic [5:0] second_stick_lines = 6'h2A;
  logic cassette_read_data = 1'b1;
  int bad_count = 0;
  int n_tests = 0;
  glue_pkg::cpu_bus_t bus;
  wire logic [7:0] data_out;
  wire logic data_drive_n;
  wire logic wait_n;
  wire logic int_n;
  glue_pkg::mem_sel_t mem_sel;
  glue_pkg::panel_out_t panel;
  wire logic [7:0] pc_seen;
  wire logic [7:0] sb_seen;

  // Pages 0..3 on slots 0..3, then reversed, then all internal
  localparam row_t ROWS [12] = '{
    '{8'hE4, 16'h0000, 1'b1, 6'h1F}, '{8'hE4, 16'h4000, 1'b1, 6'h3E},
    '{8'hE4, 16'h8000, 1'b1, 6'h3D}, '{8'hE4, 16'hC000, 1'b0, 6'h3B},
    '{8'h1B, 16'h3FFF, 1'b1, 6'h3B}, '{8'h1B, 16'h7FFF, 1'b1, 6'h3D},
    '{8'h1B, 16'hBFFF, 1'b1, 6'h3E}, '{8'h1B, 16'hFFFF, 1'b0, 6'h2F},
    '{8'h00, 16'h8000, 1'b0, 6'h37}, '{8'h00, 16'hC000, 1'b1, 6'h2F},
    '{8'h00, 16'h4000, 1'b0, 6'h3F}, '{8'h00, 16'h7FFF, 1'b1, 6'h1F}};

  // Port C bits regrouped in panel field order, sound port B bits in register bit order
  assign pc_seen = {panel.key_row_number, panel.cassette_motor_ctrl,
    panel.cassette_write_data, panel.caps_indicator_ctrl, panel.beeper_bit};
  assign sb_seen = {1'b0, panel.stick_port_choice, panel.second_stick_strobe,
    panel.first_stick_strobe, panel.joystick_scan_outputs};

  always #2.5 clk = ~clk;

  system_glue u_dut (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .bus(bus),
    .slot_int_n(slot_int_n),
    .key_sense_inputs(key_sense_inputs),
    .first_stick_lines(first_stick_lines),
    .second_stick_lines(second_stick_lines),
    .cassette_read_data(cassette_read_data),
    .data_out(data_out),
    .data_drive_n(data_drive_n),
    .wait_n(wait_n),
    .int_n(int_n),
    .mem_sel(mem_sel),
    .panel(panel)
  );

  cpu_bus_model u_cpu (
    .clk(clk),
    .bus(bus),
    .data_out(data_out),
    .data_drive_n(data_drive_n),
    .wait_n(wait_n),
    .mem_sel(mem_sel)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] pc_pins(input logic [7:0] pc);
    return {pc[3:0], pc[4], pc[5], pc[6], pc[7]};
  endfunction : pc_pins

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  // Whole run is a few hundred clocks; this is ample margin
  initial begin
    #50000;
    bad_count++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] d;
    logic drv;
    logic w1;
    logic w2;
    logic [2:0] v;
    glue_pkg::mem_sel_t s;
    glue_pkg::mem_sel_t sa;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    // Reset state
    check("sel idle", 16'(mem_sel), 16'h003F);
    check("port c reset", pc_seen, pc_pins(glue_pkg::PORT_C_RESET));
    check("snd b reset", sb_seen, glue_pkg::SND_B_RESET);
    u_cpu.io_rd(glue_pkg::IO_SLOT_SEL, d, drv);
    check("slot sel reset", d, 16'h0000);
    u_cpu.set_mode0();
    // Decode table: write select, read it back, run one access
    foreach (ROWS[i]) begin
      u_cpu.io_wr(glue_pkg::IO_SLOT_SEL, ROWS[i].sel);
      u_cpu.io_rd(glue_pkg::IO_SLOT_SEL, d, drv);
      check("slot sel rd", d, ROWS[i].sel);
      u_cpu.mem(ROWS[i].addr, ROWS[i].rd, 1'b0, s, sa, w1, w2);
      check("mem_sel", 16'(s), ROWS[i].exp);
      check("sel release", 16'(sa), 16'h003F);
      check("no wait", w1, 16'h0001);
    end
    // Opcode fetch held two clocks gets exactly one wait
    u_cpu.mem(16'h0000, 1'b1, 1'b1, s, sa, w1, w2);
    check("fetch wait", w1, 16'h0000);
    check("fetch wait end", w2, 16'h0001);
    check("fetch rom", 16'(s), 16'h001F);
    // Port C pins, beeper toggled between the two writes
    for (int i = 0; i < 2; i++) begin
      d = (i == 0) ? 8'hA5 : 8'h5A;
      u_cpu.io_wr(glue_pkg::IO_PORT_C, d);
      #1;
      check("port c", pc_seen, pc_pins(d));
    end
    @(posedge clk);
    key_sense_inputs <= 8'h3C;
    u_cpu.io_rd(glue_pkg::IO_KEY_SENSE, d, drv);
    check("key sense", d, 16'h003C);
    check("key drive", drv, 16'h0000);
    u_cpu.io_rd(8'h10, d, drv);
    check("unmapped drive", drv, 16'h0001);
    // Sound port B outputs, then port A with each stick chosen
    u_cpu.io_wr(glue_pkg::IO_SND_ADDR, 8'h0F);
    u_cpu.io_wr(glue_pkg::IO_SND_WR, 8'h3A);
    #1;
    check("snd b pins", sb_seen, 16'h003A);
    u_cpu.io_wr(glue_pkg::IO_SND_ADDR, 8'h0E);
    u_cpu.io_rd(glue_pkg::IO_SND_RD, d, drv);
    check("stick 1", d, 16'h0095);
    u_cpu.io_wr(glue_pkg::IO_SND_ADDR, 8'h0F);
    u_cpu.io_wr(glue_pkg::IO_SND_WR, 8'h40);
    cassette_read_data <= 1'b0;
    u_cpu.io_wr(glue_pkg::IO_SND_ADDR, 8'h0E);
    u_cpu.io_rd(glue_pkg::IO_SND_RD, d, drv);
    check("stick 2", d, 16'h002A);
    // Every combination of slot interrupt requests
    for (int i = 0; i < 8; i++) begin
      v = i[2:0];
      @(posedge clk);
      slot_int_n <= v;
      repeat (2) @(posedge clk);
      #1;
      check("int_n", int_n, 16'(&v));
    end
    // Clock enable low freezes the merged request
    @(posedge clk);
    ce <= 1'b0;
    slot_int_n <= 3'h6;
    repeat (3) @(posedge clk);
    #1;
    check("int frozen", int_n, 16'h0001);
    @(posedge clk);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check("int thawed", int_n, 16'h0000);
    // Mode word sends every page back to the internal slot
    u_cpu.io_wr(glue_pkg::IO_SLOT_SEL, 8'hFF);
    u_cpu.set_mode0();
    u_cpu.io_rd(glue_pkg::IO_SLOT_SEL, d, drv);
    check("mode clears sel", d, 16'h0000);
    check("mode clears c", pc_seen, pc_pins(8'h00));
    // Single bit write on the control port sets the beeper alone
    u_cpu.io_wr(glue_pkg::IO_PIO_CTRL, 8'h0F);
    #1;
    check("bit set", pc_seen, pc_pins(8'h80));
    summarize();
  end
endmodule : slot_select_and_system_io_bench

`default_nettype wire

// ==== inc/glue_pkg.sv ====
/*
  Shared constants and carriers of the system glue block: I/O port
  addresses, field positions, reset values, bus and pin structs, and the
  state records of both design modules.
  Assumes a single clock and a processor bus sampled synchronously.
*/
// Operation
// R1: Every opcode fetch cycle gets exactly one inserted wait cycle.
// R2: Slot 1 to 3 interrupt requests are ORed onto the processor interrupt.
// R3: Slot select holds four 2-bit page fields, page 0 in the low pair.
// R4: Field value is binary slot number; zero means internal ROM and RAM.
// R5: Slot 0 reads in 0000H to 7FFFH select the internal ROM.
// R6: Slot 0 accesses in 8000H to FFFFH select one internal RAM half.
// R7: Software sets the parallel chip to mode 0, three plain 8-bit ports.
// R8: Parallel port A is all output and feeds the slot select logic.
// R9: Parallel port B is all input, sensing the scanned key row.
// R10: Port C low nibble drives the keyboard row number.
// R11: Port C bit 4 drives the cassette motor relay, on when low.
// R12: Port C bit 5 carries cassette write data.
// R13: Port C bit 6 drives the caps indicator, lit when low.
// R14: Port C bit 7 is a one-bit beeper output.
// R15: Sound port A bits 0 to 5 return the selected joystick lines.
// R16: Sound port A bit 7 returns cassette read data.
// R17: Sound port B bits 0 to 3 drive joystick scan outputs.
// R18: Sound port B bit 4 is the first joystick strobe.
// R19: Sound port B bit 5 is the second joystick strobe.
// R20: Sound port B bit 6 picks the joystick read: low first, high second.
// R21: After reset the slot select register is zero, all pages slot 0.
// R22: A slot select asserts only during memory requests to its pages.
`default_nettype none

package glue_pkg;
  // ----------------------------------------------------------------------
  // I/O port addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] IO_SLOT_SEL = 8'hA8;
  localparam logic [7:0] IO_KEY_SENSE = 8'hA9;
  localparam logic [7:0] IO_PORT_C = 8'hAA;
  localparam logic [7:0] IO_PIO_CTRL = 8'hAB;
  localparam logic [7:0] IO_SND_ADDR = 8'hA0;
  localparam logic [7:0] IO_SND_WR = 8'hA1;
  localparam logic [7:0] IO_SND_RD = 8'hA2;
  localparam logic [3:0] SND_REG_PORT_A = 4'hE;
  localparam logic [3:0] SND_REG_PORT_B = 4'hF;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int CTRL_MODE_BIT = 7;
  localparam int SA_TAPE_BIT = 7;
  localparam logic [1:0] SLOT_INTERNAL = 2'h0;
  localparam int NUM_EXT_SLOTS = 3;
  localparam int NUM_RAM_HALVES = 2;
  localparam logic [7:0] SLOT_SEL_RESET = 8'h00;
  localparam logic [7:0] PORT_C_RESET = 8'h50;
  localparam logic [7:0] SND_B_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
    logic mreq_n;
    logic iorq_n;
    logic rd_n;
    logic wr_n;
    logic m1_n;
  } cpu_bus_t;

  typedef struct packed {
    logic rom_cs_n;
    logic [1:0] ram_cs_n;
    logic [2:0] slot_sel_n;
  } mem_sel_t;

  typedef struct packed {
    logic [3:0] key_row_number;
    logic cassette_motor_ctrl;
    logic cassette_write_data;
    logic caps_indicator_ctrl;
    logic beeper_bit;
    logic [3:0] joystick_scan_outputs;
    logic first_stick_strobe;
    logic second_stick_strobe;
    logic stick_port_choice;
  } panel_out_t;

  typedef struct packed {
    logic [7:0] slot_sel_reg;
    logic [7:0] port_c_reg;
    logic [3:0] snd_addr_reg;
    logic [7:0] snd_b_reg;
    logic io_done;
    logic [7:0] data_out;
    logic data_drive_n;
    logic int_n;
    mem_sel_t mem_sel;
  } top_state_t;

  localparam top_state_t TOP_RESET = '{
    slot_sel_reg: SLOT_SEL_RESET, port_c_reg: PORT_C_RESET,
    snd_addr_reg: 4'h0, snd_b_reg: SND_B_RESET, io_done: 1'b0,
    data_out: 8'h00, data_drive_n: 1'b1, int_n: 1'b1,
    mem_sel: 6'h3F};

  // Wait inserter states, one-hot
  typedef enum logic [2:0] {
    WAIT_IDLE = 3'b001,
    WAIT_INSERT = 3'b010,
    WAIT_HOLD = 3'b100
  } wait_state_t;

  typedef struct packed {
    wait_state_t state;
    logic wait_n;
  } wait_rec_t;

  localparam wait_rec_t WAIT_RESET = '{state: WAIT_IDLE, wait_n: 1'b1};
endpackage : glue_pkg

`default_nettype wire

// ==== src/fetch_wait_gen.sv ====
/*
  Opcode fetch wait inserter: holds the processor wait line low for one
  processor cycle at the start of each fetch.
  Assumes ce marks one processor clock and reset is already synchronised.
*/
`default_nettype none

module fetch_wait_gen (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic fetch_active,
  output logic wait_n
);
  glue_pkg::wait_rec_t st_reg;
  glue_pkg::wait_rec_t st_next;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // Hold state stops a long fetch from earning a second wait
  always_comb begin
    st_next = st_reg;
    case (st_reg.state)
      glue_pkg::WAIT_IDLE: begin
        if (fetch_active) begin
          st_next.state = glue_pkg::WAIT_INSERT; // [R1]
          st_next.wait_n = 1'b0;
        end
      end
      glue_pkg::WAIT_INSERT: begin
        st_next.state = glue_pkg::WAIT_HOLD;
        st_next.wait_n = 1'b1; // [R1]
      end
      glue_pkg::WAIT_HOLD: begin
        if (!fetch_active) begin
          st_next.state = glue_pkg::WAIT_IDLE;
        end
      end
      default: begin
        st_next = glue_pkg::WAIT_RESET;
      end
    endcase
  end

  // State register, frozen while ce is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= glue_pkg::WAIT_RESET;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign wait_n = st_reg.wait_n;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_fetch_start;
    ce && fetch_active && st_reg.state == glue_pkg::WAIT_IDLE;
  endsequence

  property p_wait_starts;
    @(posedge clk) disable iff (!rst_n) s_fetch_start |=> !wait_n;
  endproperty
  a_wait_starts: assert property (p_wait_starts) // [R1]
    else $error("fetch did not get a wait cycle");

  property p_wait_single;
    @(posedge clk) disable iff (!rst_n)
      (ce && !wait_n) |=> wait_n ##1 (wait_n || !$past(fetch_active, 2));
  endproperty
  a_wait_single: assert property (p_wait_single) // [R1]
    else $error("wait held longer than one cycle");
endmodule : fetch_wait_gen

`default_nettype wire

// ==== src/system_glue.sv ====
/*
  System glue top: slot select register and page decoder, internal ROM
  and RAM selects, fetch wait, slot interrupt merge, and the parallel and
  sound chip I/O port bits for keyboard, cassette, beeper and joysticks.
  Assumes the processor bus is synchronous to clk and ce marks each
  processor clock; the data bus wire is resolved outside from data_drive_n.
*/
`default_nettype none

module system_glue (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire glue_pkg::cpu_bus_t bus,
  input wire logic [2:0] slot_int_n,
  input wire logic [7:0] key_sense_inputs,
  input wire logic [5:0] first_stick_lines,
  input wire logic [5:0] second_stick_lines,
  input wire logic cassette_read_data,
  output logic [7:0] data_out,
  output logic data_drive_n,
  output logic wait_n,
  output logic int_n,
  output glue_pkg::mem_sel_t mem_sel,
  output glue_pkg::panel_out_t panel
);
  glue_pkg::top_state_t st_reg;
  glue_pkg::top_state_t st_next;
  logic [1:0] rst_sync_reg;
  logic rst_sync_n;
  logic [1:0] page;
  logic [1:0] field;
  logic mem_req;
  logic fetch_active;
  logic io_go;
  logic [2:0] slot_hit;
  logic [1:0] ram_hit;
  logic rom_hit;
  logic [5:0] stick_lines;

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  // Two stages so release never lands near an edge of the state flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_reg <= 2'h0;
    end else if (ce) begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_sync_n = rst_sync_reg[1];

  // ----------------------------------------------------------------------
  // Page decode
  // ----------------------------------------------------------------------
  // Top two address bits pick the page, its pair in the register the slot
  assign page = bus.addr[15:14];
  assign field = 2'(st_reg.slot_sel_reg >> {page, 1'b0}); // [R3] [R8]
  assign mem_req = !bus.mreq_n;
  assign fetch_active = !bus.m1_n && !bus.mreq_n;

  // External slot selects, one per slot 1 to 3
  genvar gi;
  generate
    for (gi = 0; gi < glue_pkg::NUM_EXT_SLOTS; gi++) begin : g_slot
      assign slot_hit[gi] = mem_req && field == 2'(gi + 1); // [R4] [R22]
    end
    for (gi = 0; gi < glue_pkg::NUM_RAM_HALVES; gi++) begin : g_ram
      // Upper page pair only, one RAM half per page
      assign ram_hit[gi] = mem_req && field == glue_pkg::SLOT_INTERNAL
                           && page == {1'b1, 1'(gi)}; // [R6] [R4]
    end
  endgenerate

  // ROM answers reads only; writes to slot 0 low pages go nowhere
  assign rom_hit = mem_req && !bus.rd_n && !page[1]
                   && field == glue_pkg::SLOT_INTERNAL; // [R5] [R4]

  // Joystick port chosen by sound port B bit 6
  assign stick_lines = st_reg.snd_b_reg[6] ? second_stick_lines
                       : first_stick_lines; // [R20] [R15]

  // Interrupt acknowledge carries IORQ with M1 and is not a port access
  assign io_go = !bus.iorq_n && bus.m1_n && (!bus.rd_n || !bus.wr_n)
                 && !st_reg.io_done;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // One I/O strobe acts once; io_done drops when IORQ goes away
  always_comb begin
    logic [7:0] rd_val;
    logic rd_hit;
    rd_val = 8'h00;
    rd_hit = 1'b0;
    st_next = st_reg;
    // Memory selects follow the bus one clock later
    st_next.mem_sel.slot_sel_n = ~slot_hit; // [R22]
    st_next.mem_sel.ram_cs_n = ~ram_hit; // [R6]
    st_next.mem_sel.rom_cs_n = !rom_hit; // [R5]
    st_next.int_n = &slot_int_n; // [R2]
    if (bus.iorq_n || bus.rd_n) begin
      st_next.data_drive_n = 1'b1;
    end
    if (bus.iorq_n) begin
      st_next.io_done = 1'b0;
    end
    if (io_go) begin
      st_next.io_done = 1'b1;
      if (!bus.wr_n) begin
        // Write decode
        if (bus.addr[7:0] == glue_pkg::IO_SLOT_SEL) begin
          st_next.slot_sel_reg = bus.data; // [R8] [R3]
        end else if (bus.addr[7:0] == glue_pkg::IO_PORT_C) begin
          st_next.port_c_reg = bus.data; // [R10] [R11] [R12] [R13] [R14]
        end else if (bus.addr[7:0] == glue_pkg::IO_PIO_CTRL) begin
          if (bus.data[glue_pkg::CTRL_MODE_BIT]) begin
            // Mode word clears output latches, as the chip does
            st_next.slot_sel_reg = 8'h00;
            st_next.port_c_reg = 8'h00;
          end else begin
            // Single bit set or reset, the usual way to toggle the beeper
            st_next.port_c_reg[bus.data[3:1]] = bus.data[0]; // [R14]
          end
        end else if (bus.addr[7:0] == glue_pkg::IO_SND_ADDR) begin
          st_next.snd_addr_reg = bus.data[3:0];
        end else if (bus.addr[7:0] == glue_pkg::IO_SND_WR) begin
          if (st_reg.snd_addr_reg == glue_pkg::SND_REG_PORT_B) begin
            st_next.snd_b_reg = bus.data; // [R17] [R18] [R19] [R20]
          end
        end
      end else begin
        // Read decode; unmapped ports leave the bus undriven
        rd_hit = 1'b1;
        if (bus.addr[7:0] == glue_pkg::IO_SLOT_SEL) begin
          rd_val = st_reg.slot_sel_reg;
        end else if (bus.addr[7:0] == glue_pkg::IO_KEY_SENSE) begin
          rd_val = key_sense_inputs; // [R9]
        end else if (bus.addr[7:0] == glue_pkg::IO_PORT_C) begin
          rd_val = st_reg.port_c_reg;
        end else if (bus.addr[7:0] == glue_pkg::IO_SND_RD) begin
          if (st_reg.snd_addr_reg == glue_pkg::SND_REG_PORT_A) begin
            rd_val = {cassette_read_data, 1'b0, stick_lines}; // [R15] [R16]
          end else if (st_reg.snd_addr_reg == glue_pkg::SND_REG_PORT_B) begin
            rd_val = st_reg.snd_b_reg;
          end
        end else begin
          rd_hit = 1'b0;
        end
        if (rd_hit) begin
          st_next.data_out = rd_val;
          st_next.data_drive_n = 1'b0;
        end
      end
    end
  end

  // State register, frozen while ce is low
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_reg <= glue_pkg::TOP_RESET; // [R21]
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------
  // Fetch wait
  // ----------------------------------------------------------------------
  fetch_wait_gen u_wait (
    .clk(clk),
    .rst_n(rst_sync_n),
    .ce(ce),
    .fetch_active(fetch_active),
    .wait_n(wait_n)
  );

  // ----------------------------------------------------------------------
  // Outputs, all wired straight from state flops
  // ----------------------------------------------------------------------
  assign data_out = st_reg.data_out;
  assign data_drive_n = st_reg.data_drive_n;
  assign int_n = st_reg.int_n;
  assign mem_sel = st_reg.mem_sel;
  // One driver for the whole panel struct, members mapped bit by bit
  assign panel = '{
    key_row_number: st_reg.port_c_reg[3:0], // [R10]
    cassette_motor_ctrl: st_reg.port_c_reg[4], // [R11]
    cassette_write_data: st_reg.port_c_reg[5], // [R12]
    caps_indicator_ctrl: st_reg.port_c_reg[6], // [R13]
    beeper_bit: st_reg.port_c_reg[7], // [R14]
    joystick_scan_outputs: st_reg.snd_b_reg[3:0], // [R17]
    first_stick_strobe: st_reg.snd_b_reg[4], // [R18]
    second_stick_strobe: st_reg.snd_b_reg[5], // [R19]
    stick_port_choice: st_reg.snd_b_reg[6] // [R20]
  };

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_sync_n);

  sequence s_io_wr(logic [7:0] port);
    ce && io_go && !bus.wr_n && bus.addr[7:0] == port;
  endsequence

  sequence s_io_rd(logic [7:0] port);
    ce && io_go && bus.wr_n && bus.addr[7:0] == port;
  endsequence

  property p_slot_write;
    s_io_wr(glue_pkg::IO_SLOT_SEL) |=>
      st_reg.slot_sel_reg == $past(bus.data);
  endproperty
  a_slot_write: assert property (p_slot_write) // [R8]
    else $error("slot select write not stored");

  property p_int_merge;
    ce |=> int_n == $past(&slot_int_n);
  endproperty
  a_int_merge: assert property (p_int_merge) // [R2]
    else $error("interrupt not the OR of slot requests");

  property p_slot1_sel;
    ce |=> (mem_sel.slot_sel_n[0] == 1'b0)
      == $past(!bus.mreq_n && field == 2'h1);
  endproperty
  a_slot1_sel: assert property (p_slot1_sel) // [R22]
    else $error("slot 1 select wrong for request and field");

  property p_rom_sel;
    ce |=> (mem_sel.rom_cs_n == 1'b0) == $past(!bus.mreq_n && !bus.rd_n
      && bus.addr[15] == 1'b0 && field == 2'h0);
  endproperty
  a_rom_sel: assert property (p_rom_sel) // [R5]
    else $error("ROM select wrong");

  property p_ram_sel;
    ce && !bus.mreq_n && bus.addr[15:14] == 2'h3
      && st_reg.slot_sel_reg[7:6] == 2'h0 |=>
      mem_sel.ram_cs_n == 2'h1 && mem_sel.slot_sel_n == 3'h7;
  endproperty
  a_ram_sel: assert property (p_ram_sel) // [R6]
    else $error("upper RAM half not selected alone");

  property p_stick_read;
    s_io_rd(glue_pkg::IO_SND_RD)
      ##0 (st_reg.snd_addr_reg == glue_pkg::SND_REG_PORT_A) |=>
      data_out[5:0] == ($past(st_reg.snd_b_reg[6]) ?
      $past(second_stick_lines) : $past(first_stick_lines))
      && !data_drive_n;
  endproperty
  a_stick_read: assert property (p_stick_read) // [R20]
    else $error("joystick readback from wrong port");

  property p_reset_map;
    $rose(rst_sync_n) |-> st_reg.slot_sel_reg == 8'h00;
  endproperty
  a_reset_map: assert property (p_reset_map) // [R21]
    else $error("slot select not zero after reset");

  property p_bit_set;
    s_io_wr(glue_pkg::IO_PIO_CTRL) ##0 !bus.data[7] |=>
      st_reg.port_c_reg[$past(bus.data[3:1])] == $past(bus.data[0]);
  endproperty
  a_bit_set: assert property (p_bit_set) // [R14]
    else $error("port C bit set or reset failed");

  property p_port_c_write;
    s_io_wr(glue_pkg::IO_PORT_C) |=> st_reg.port_c_reg == $past(bus.data);
  endproperty
  a_port_c_write: assert property (p_port_c_write) // [R10]
    else $error("port C write not stored");

  // A driven data bus must let go once the I/O request ends
  property p_drive_release;
    ce && !data_drive_n && bus.iorq_n |=> data_drive_n;
  endproperty
  a_drive_release: assert property (p_drive_release) // [R9]
    else $error("data bus still driven after the request");
endmodule : system_glue

`default_nettype wire
